// [hdl/ats_defines.vh]
// Purpose: Register offsets, field positions, reset values and timing for the timer crossing.
// Assumes: Plain register port, one byte per offset.
// Notes: Definitions only.
`ifndef ATS_DEFINES_VH
`define ATS_DEFINES_VH
// Register offsets
`define ATS_OFS_COUNT 3'h0
`define ATS_OFS_CMP_A 3'h1
`define ATS_OFS_CMP_B 3'h2
`define ATS_OFS_CTL_A 3'h3
`define ATS_OFS_CTL_B 3'h4
`define ATS_OFS_STATUS 3'h5
`define ATS_OFS_MASK 3'h6
`define ATS_OFS_FLAGS 3'h7
// Status register fields
`define ATS_BIT_EXT_CLK 6
`define ATS_BIT_ASYNC 5
`define ATS_BIT_BUSY_CNT 4
`define ATS_BIT_BUSY_CA 3
`define ATS_BIT_BUSY_CB 2
`define ATS_BIT_BUSY_TA 1
`define ATS_BIT_BUSY_TB 0
// Mask and flag fields
`define ATS_BIT_CMP_B 2
`define ATS_BIT_CMP_A 1
`define ATS_BIT_OVF 0
// Reset values
`define ATS_RST_BYTE 8'h00
`define ATS_RST_MASK3 3'h0
// Flag crossing: processor cycles after the timer edge
`define ATS_FLAG_SYNC_CYC 3
`endif

// [hdl/ats_timer_sync.v]
// Purpose: Timer register crossing: staging, busy flags, counter readback, flag sync, irq enables.
// Assumes: Timer clock sampled from the oscillator pin at mclk_i; mclk far above 4x pin rate.
// Notes: Counter runs here in a simple free-run form so the crossing has a destination.
`timescale 1ns/1ps
`include "ats_defines.vh"

module ats_timer_sync #(
    parameter NREG = 5
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Register port
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    // Oscillator pin, power state and interrupt inputs
    input wire oscillator_input_pin_i,
    input wire global_irq_enable_i,
    input wire sleep_i,
    input wire deep_sleep_i,
    input wire [2:0] irq_ack_i,
    // Outputs
    output wire ext_clock_buffer_en_o,
    output wire crystal_osc_en_o,
    output reg waveform_out_a_o,
    output reg waveform_out_b_o,
    output wire [2:0] irq_req_o,
    output reg wake_o
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchroniser and edge detection
reg pin_s1;
reg pin_s2;
reg pin_s3;
always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        pin_s1 <= 1'b0;
        pin_s2 <= 1'b0;
        pin_s3 <= 1'b0;
    end else begin
        pin_s1 <= oscillator_input_pin_i;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
    end
end

reg external_clock_enable;
reg async_select;
wire pin_rise = pin_s2 & ~pin_s3;
// Timer tick from the processor clock or the pin
wire tick = async_select ? pin_rise : 1'b1;
// Input buffer and crystal gating
assign ext_clock_buffer_en_o = external_clock_enable & async_select;
// Crystal runs only in async mode without the external clock, and is held off in deep sleep
assign crystal_osc_en_o = ~external_clock_enable & async_select & ~deep_sleep_i;

////////////////////////////////////////////////////////////////////////////////
// Staging registers, one per destination
reg [7:0] stage [0:NREG-1];
reg [7:0] dest [0:NREG-1];
reg [NREG-1:0] pend;     // Staged value awaiting transfer
reg [1:0] edge_cnt [0:NREG-1];
reg [NREG-1:0] done_tgl; // Toggles when a transfer lands
reg [NREG-1:0] done_s1;
reg [NREG-1:0] done_s2;
reg [NREG-1:0] done_s3;
reg [NREG-1:0] busy;
reg [7:0] timer_count;
wire cnt_load = pend[0] && edge_cnt[0] == 2'd1 && pin_rise;

genvar g;
generate
    for (g = 0; g < NREG; g = g + 1) begin : gen_stage
        wire hit = wr_i && addr_i == g;
        always @(posedge mclk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                stage[g] <= `ATS_RST_BYTE;
                pend[g] <= 1'b0;
                edge_cnt[g] <= 2'd0;
                done_tgl[g] <= 1'b0;
                busy[g] <= 1'b0;
                done_s1[g] <= 1'b0;
                done_s2[g] <= 1'b0;
                done_s3[g] <= 1'b0;
            end else begin
                // Clear returns through two stages before busy drops
                done_s1[g] <= done_tgl[g];
                done_s2[g] <= done_s1[g];
                done_s3[g] <= done_s2[g];
                if (hit) begin
                    stage[g] <= wdata_i;
                end
                if (hit && async_select) begin
                    pend[g] <= 1'b1;
                    edge_cnt[g] <= 2'd0;
                    busy[g] <= 1'b1;
                end else begin
                    if (pend[g] && pin_rise) begin
                        if (edge_cnt[g] == 2'd1) begin
                            pend[g] <= 1'b0;
                            done_tgl[g] <= ~done_tgl[g];
                        end else begin
                            edge_cnt[g] <= edge_cnt[g] + 2'd1;
                        end
                    end
                    if (done_s2[g] != done_s3[g] && !pend[g]) begin
                        busy[g] <= 1'b0;
                    end
                end
                if (!async_select) begin
                    pend[g] <= 1'b0;
                    busy[g] <= 1'b0;
                end
            end
        end
        // Destination load: direct in sync mode, after two pin edges in async
        if (g != 0) begin : gen_dest
            always @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    dest[g] <= `ATS_RST_BYTE;
                end else if (hit && !async_select) begin
                    dest[g] <= wdata_i;
                end else if (pend[g] && edge_cnt[g] == 2'd1 && pin_rise) begin
                    dest[g] <= stage[g];
                end
            end
        end else begin : gen_cnt
            always @* dest[g] = timer_count;
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Counter and compare on the timer tick
reg [7:0] count_view;
reg [2:0] raw_evt;
wire cmp_block = pend[0] | pend[1] | pend[2] | cnt_load;
always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        timer_count <= `ATS_RST_BYTE;
        count_view <= `ATS_RST_BYTE;
        raw_evt <= `ATS_RST_MASK3;
        waveform_out_a_o <= 1'b0;
        waveform_out_b_o <= 1'b0;
    end else begin
        raw_evt <= `ATS_RST_MASK3;
        if (wr_i && addr_i == `ATS_OFS_COUNT && !async_select) begin
            timer_count <= wdata_i;
        end else if (cnt_load) begin
            timer_count <= stage[0];
        end else if (tick && dest[4] != `ATS_RST_BYTE) begin
            timer_count <= timer_count + 8'h01;
            raw_evt[`ATS_BIT_OVF] <= timer_count == 8'hFF;
            if (!cmp_block) begin
                if (timer_count == dest[1]) begin
                    raw_evt[`ATS_BIT_CMP_A] <= 1'b1;
                    waveform_out_a_o <= ~waveform_out_a_o;
                end
                if (timer_count == dest[2]) begin
                    raw_evt[`ATS_BIT_CMP_B] <= 1'b1;
                    waveform_out_b_o <= ~waveform_out_b_o;
                end
            end
        end
        // Readback copy refreshed on each rising pin edge
        if (!async_select || pin_rise) begin
            count_view <= timer_count;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Flag crossing: event delayed a fixed number of processor cycles in async mode, taken directly in sync mode
reg [2:0] evt_dly [0:`ATS_FLAG_SYNC_CYC-1];
reg [2:0] flags;
reg [2:0] irq_mask;
reg [2:0] clr;
integer i;
always @* begin
    clr = `ATS_RST_MASK3;
    if (wr_i && addr_i == `ATS_OFS_FLAGS) begin
        clr = wdata_i[2:0];
    end
    clr = clr | irq_ack_i;
end

always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        for (i = 0; i < `ATS_FLAG_SYNC_CYC; i = i + 1) begin
            evt_dly[i] <= `ATS_RST_MASK3;
        end
        flags <= `ATS_RST_MASK3;
        wake_o <= 1'b0;
    end else begin
        // Async mode adds the processor-side stages after the tick
        evt_dly[0] <= raw_evt;
        for (i = 1; i < `ATS_FLAG_SYNC_CYC; i = i + 1) begin
            evt_dly[i] <= evt_dly[i-1];
        end
        // Set wins over a same-cycle clear
        if (async_select) begin
            flags <= (flags & ~clr) | evt_dly[`ATS_FLAG_SYNC_CYC-1];
        end else begin
            flags <= (flags & ~clr) | raw_evt;
        end
        // Wake-up begins on the tick after the condition
        if (!sleep_i) begin
            wake_o <= 1'b0;
        end else if (tick && |(flags & irq_mask)) begin
            wake_o <= 1'b1;
        end
    end
end

assign irq_req_o = flags & irq_mask & {3{global_irq_enable_i}};

////////////////////////////////////////////////////////////////////////////////
// Control registers and register port
always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        external_clock_enable <= 1'b0;
        async_select <= 1'b0;
        irq_mask <= `ATS_RST_MASK3;
    end else if (wr_i && addr_i == `ATS_OFS_STATUS) begin
        external_clock_enable <= wdata_i[`ATS_BIT_EXT_CLK];
        async_select <= wdata_i[`ATS_BIT_ASYNC];
    end else if (wr_i && addr_i == `ATS_OFS_MASK) begin
        irq_mask <= wdata_i[2:0];
    end
end

always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        rdata_o <= `ATS_RST_BYTE;
    end else if (rd_i) begin
        case (addr_i)
            `ATS_OFS_COUNT: rdata_o <= async_select ? count_view : timer_count;
            // Busy index 0 (counter) sits at bit 4, control B at bit 0
            `ATS_OFS_STATUS: rdata_o <= {1'b0, external_clock_enable, async_select,
                busy[0], busy[1], busy[2], busy[3], busy[4]};
            `ATS_OFS_MASK: rdata_o <= {5'h00, irq_mask};
            `ATS_OFS_FLAGS: rdata_o <= {5'h00, flags};
            default: rdata_o <= stage[addr_i];
        endcase
    end else begin
        rdata_o <= `ATS_RST_BYTE;
    end
end

endmodule

// [testbench/ats_timer_sync_assertions.sv]
// Purpose: Port-level checks for the timer register crossing.
// Assumes: One mclk_i domain; rst_n_i active low.
// Notes: Keeps its own copy of the enable mask, rebuilt from port writes.
`timescale 1ns/1ps
`include "ats_defines.vh"
module ats_timer_sync_assertions (
    // Clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // Register port
    input wire [2:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    // Power and interrupt side
    input wire global_irq_enable_i,
    input wire sleep_i,
    input wire deep_sleep_i,
    input wire ext_clock_buffer_en_o,
    input wire crystal_osc_en_o,
    input wire [2:0] irq_req_o,
    input wire wake_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    reg [2:0] mask;
    ////////////////////////////////////////////////////////////////////////////////
    // Mask copy, so a request can be traced to its enable
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            mask <= 3'h0;
        else if (wr_i && addr_i == `ATS_OFS_MASK)
            mask <= wdata_i[2:0];
    end
    irq_global_a: assert property (irq_req_o != 3'h0 |-> global_irq_enable_i)
        else $error("request without global enable");
    irq_mask_a: assert property ((irq_req_o & ~mask) == 3'h0)
        else $error("request on a masked source");
    rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read slot");
    xtal_excl_a: assert property (!(ext_clock_buffer_en_o && crystal_osc_en_o))
        else $error("buffer and crystal both on");
    deep_xtal_a: assert property (deep_sleep_i |-> !crystal_osc_en_o)
        else $error("crystal on in deep sleep");
    wake_sleep_a: assert property (!sleep_i |=> !wake_o)
        else $error("wake held while awake");
    ext_buf_a: assert property (wr_i && addr_i == `ATS_OFS_STATUS |=>
        ext_clock_buffer_en_o == ($past(wdata_i[6]) && $past(wdata_i[5])))
        else $error("buffer enable wrong after status write");
    xtal_wr_a: assert property (wr_i && addr_i == `ATS_OFS_STATUS |=>
        crystal_osc_en_o == ($past(wdata_i[5]) && !$past(wdata_i[6]) && !deep_sleep_i))
        else $error("crystal enable wrong after status write");
    mask_rsvd_a: assert property (rd_i && addr_i == `ATS_OFS_MASK |=> rdata_o[7:3] == 5'h00)
        else $error("mask upper bits not zero");
endmodule

// [testbench/ats_osc_model.sv]
// Purpose: Oscillator pin source for the timer crossing.
// Assumes: 125 ns period, far below a quarter of the processor clock.
// Notes: Pin rests low while stopped, never frozen mid-level.
`timescale 1ns/1ps
module ats_osc_model (
    // Control and pin
    input wire run_i,
    output reg pin_o
);
    // Half-period toggle; stopping drops the pin low
    initial pin_o = 1'b0;
    always begin
        #62.5;
        pin_o = run_i ? ~pin_o : 1'b0;
    end
endmodule

// [testbench/tb.sv]
// Purpose: Self-checking bench for the timer register crossing.
// Assumes: Register port with read data one cycle after the strobe.
// Notes: Sync mode is used for interrupt tests so overflow comes fast.
`timescale 1ns/1ps
`include "ats_defines.vh"
module tb;
    reg mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, osc_run = 1'b0;
    reg global_irq_enable_i = 1'b0, sleep_i = 1'b0, deep_sleep_i = 1'b0;
    reg [2:0] addr_i = 3'h0, irq_ack_i = 3'h0;
    reg [7:0] wdata_i = 8'h00, got;
    wire [7:0] rdata_o;
    wire [2:0] irq_req_o;
    wire pin, ext_buf, xtal, wav_a, wav_b, wake_o;
    integer failures = 0, cmp_count = 0, n;
    ats_timer_sync uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .oscillator_input_pin_i(pin),
        .global_irq_enable_i(global_irq_enable_i), .sleep_i(sleep_i),
        .deep_sleep_i(deep_sleep_i), .irq_ack_i(irq_ack_i), .ext_clock_buffer_en_o(ext_buf),
        .crystal_osc_en_o(xtal), .waveform_out_a_o(wav_a), .waveform_out_b_o(wav_b),
        .irq_req_o(irq_req_o), .wake_o(wake_o));
    ats_osc_model osc (.run_i(osc_run), .pin_o(pin));
    initial forever #4 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////////////////////
    task ck(input logic [7:0] g, input logic [7:0] e, input string m);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
            end
        end
    endtask
    // Strobes raised after an edge, dropped after the edge that takes them
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge mclk_i);
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            @(posedge mclk_i);
            wr_i <= 1'b0;
        end
    endtask
    task rc(input [2:0] a, input [7:0] m, input [7:0] e, input string s);
        begin
            @(posedge mclk_i);
            addr_i <= a;
            rd_i <= 1'b1;
            @(posedge mclk_i);
            rd_i <= 1'b0;
            #1 got = rdata_o & m;
            if (s != "") ck(got, e, s);
        end
    endtask
    task wait_irq;
        begin
            n = 0;
            while (irq_req_o[0] !== 1'b1 && n < 700) begin
                @(posedge mclk_i);
                n = n + 1;
            end
            #1 ck({7'h0, irq_req_o[0]}, 8'h01, "overflow request");
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, failures);
            if (failures == 0 && cmp_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        failures = failures + 1;
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rc(`ATS_OFS_STATUS, 8'hFF, 8'h00, "status reset");
        rc(`ATS_OFS_MASK, 8'hFF, 8'h00, "mask reset");
        rc(`ATS_OFS_FLAGS, 8'hFF, 8'h00, "flags reset");
        // Sync mode: no busy, direct load
        wr(`ATS_OFS_CMP_A, 8'h55);
        rc(`ATS_OFS_STATUS, 8'hFF, 8'h00, "sync busy");
        rc(`ATS_OFS_CMP_A, 8'hFF, 8'h55, "sync cmp a");
        wr(`ATS_OFS_MASK, 8'hFF);
        rc(`ATS_OFS_MASK, 8'hFF, 8'h07, "mask bits");
        $display("test sync registers done");
        // External enable first, then select; then crystal path
        wr(`ATS_OFS_STATUS, 8'h40);
        wr(`ATS_OFS_STATUS, 8'h60);
        #1 ck({6'h0, ext_buf, xtal}, 8'h02, "ext buffer");
        wr(`ATS_OFS_STATUS, 8'h20);
        #1 ck({6'h0, ext_buf, xtal}, 8'h01, "crystal");
        @(posedge mclk_i);
        deep_sleep_i <= 1'b1;
        @(posedge mclk_i);
        #1 ck({7'h0, xtal}, 8'h00, "deep sleep crystal");
        deep_sleep_i <= 1'b0;
        // Two staged writes in flight at once
        osc_run = 1'b1;
        wr(`ATS_OFS_CMP_B, 8'hA5);
        wr(`ATS_OFS_CMP_A, 8'h3C);
        rc(`ATS_OFS_STATUS, 8'hFF, 8'h2C, "busy set");
        rc(`ATS_OFS_CMP_B, 8'hFF, 8'hA5, "staged cmp b");
        n = 0;
        got = 8'hFF;
        while (got !== 8'h20 && n < 100) begin
            rc(`ATS_OFS_STATUS, 8'hFF, 8'h00, "");
            n = n + 1;
        end
        ck({7'h0, n > 3 && n < 30}, 8'h01, "transfer time");
        rc(`ATS_OFS_CMP_A, 8'hFF, 8'h3C, "cmp a after xfer");
        rc(`ATS_OFS_COUNT, 8'hFF, 8'h00, "count view stopped");
        $display("test async staging done");
        // Return to sync with the safe switching order
        wr(`ATS_OFS_MASK, 8'h00);
        wr(`ATS_OFS_STATUS, 8'h00);
        wr(`ATS_OFS_CTL_B, 8'h01);
        wr(`ATS_OFS_FLAGS, 8'h07);
        wr(`ATS_OFS_MASK, 8'h01);
        global_irq_enable_i <= 1'b1;
        wait_irq;
        ck({6'h0, wav_a, wav_b}, 8'h03, "waveforms toggled");
        rc(`ATS_OFS_FLAGS, 8'h01, 8'h01, "overflow flag");
        sleep_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 ck({7'h0, wake_o}, 8'h01, "wake");
        sleep_i <= 1'b0;
        global_irq_enable_i <= 1'b0;
        @(posedge mclk_i);
        #1 ck({5'h0, irq_req_o}, 8'h00, "global off");
        global_irq_enable_i <= 1'b1;
        irq_ack_i <= 3'h1;
        @(posedge mclk_i);
        irq_ack_i <= 3'h0;
        rc(`ATS_OFS_FLAGS, 8'h01, 8'h00, "ack clears");
        wait_irq;
        wr(`ATS_OFS_FLAGS, 8'h01);
        rc(`ATS_OFS_FLAGS, 8'h01, 8'h00, "write one clears");
        $display("test interrupts done");
        report_and_stop;
    end
endmodule
bind ats_timer_sync ats_timer_sync_assertions u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .global_irq_enable_i(global_irq_enable_i), .sleep_i(sleep_i), .deep_sleep_i(deep_sleep_i),
    .ext_clock_buffer_en_o(ext_clock_buffer_en_o), .crystal_osc_en_o(crystal_osc_en_o),
    .irq_req_o(irq_req_o), .wake_o(wake_o));
